// *** inc/rtps_pkg.sv ***
// Purpose: Shared constants and types of the transmit packet sequencer.
// Assumes: One 100 MHz clock; register offsets are byte addresses.
// Notes: Timing figures are in their own units; cycle counts derive here.
package rtps_pkg;
  localparam logic [9:0] PRE_CNT_OFS = 10'h102;
  localparam logic [9:0] SYNC_LO_OFS = 10'h10C;
  localparam logic [9:0] SYNC_MID_OFS = 10'h10D;
  localparam logic [9:0] SYNC_HI_OFS = 10'h10E;
  localparam logic [9:0] MODE_OFS = 10'h13E;
  localparam logic [9:0] TX_BASE_OFS = 10'h314;
  localparam logic [9:0] PRE_EXTRA_OFS = 10'h3F3;
  localparam logic [9:0] SLOT_OFS = 10'h3E0;
  localparam logic [9:0] SLOT_EXT_OFS = 10'h3E1;
  localparam logic [9:0] CTRL_OFS = 10'h3E2;
  localparam logic [9:0] CAL_OFS = 10'h3E3;
  localparam logic [9:0] STATUS_OFS = 10'h3E4;
  localparam int CRC_OFF_BIT = 0;
  localparam int TURN_EN_BIT = 1;
  localparam int EXTPA_EN_BIT = 2;
  localparam int RDY_IE_BIT = 3;
  localparam int SFD_IE_BIT = 4;
  localparam int SENT_IE_BIT = 5;
  localparam int RXP_IE_BIT = 6;
  localparam logic [7:0] SLOT_DLY_RST = 8'hC0;
  localparam logic [7:0] SLOT_EXT_RST = 8'h00;
  localparam logic [3:0] MODE_154 = 4'h0;
  localparam logic [3:0] MODE_FSK = 4'h4;
  localparam logic [3:0] CAL_SKIP = 4'hF;
  localparam logic [3:0] CAL_RUN = 4'h9;
  localparam logic [7:0] CMD_TX = 8'h01;
  localparam logic [7:0] CMD_RX = 8'h02;
  localparam logic [7:0] CMD_IDLE = 8'h03;
  localparam logic [7:0] CMD_RDY = 8'h04;
  localparam logic [7:0] FILL_BYTE = 8'hAA;
  localparam logic [7:0] PRE_154 = 8'h00;
  localparam logic [7:0] SFD_154 = 8'hA7;
  localparam logic [8:0] PRE154_N = 9'h004;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam int CLK_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int BIT_NS = 4000;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int RX_IRQ_US = 38;
  localparam int RX_IRQ_CYC = RX_IRQ_US * US_NS / CLK_NS;
  localparam int RAMP_US = 8;
  localparam int PA_LEAD_US = 10;
  localparam int CAL_US = 60;
  localparam int ABORT_US = 100;
  localparam int EXT_DL_US = 150;
  typedef enum logic [3:0] {
    S_IDLE, S_RDY, S_RX, S_WAIT, S_DELAY, S_PRE, S_SYNC, S_PAY, S_CRC, S_POST
  } rtps_state_t;
  typedef struct packed {
    rtps_state_t st;
    logic [2:0] csSync;
    logic csLvl;
    logic csOld;
    logic [6:0] usDiv;
    logic [11:0] elapsed;
    logic [7:0] extLat;
    logic extFrz;
    logic rxOn;
    logic [11:0] rxCnt;
    logic [8:0] bitTmr;
    logic [2:0] bitCnt;
    logic [7:0] sh;
    logic [8:0] byteCnt;
    logic [15:0] crc;
    logic [7:0] ramAddr;
    logic txBit, txStb, txAct, paOn, rampUp, rampDn, extPa, cal;
    logic rdyIrq, sfdIrq, sentIrq, rxIrq;
    logic [7:0] slotDly, slotExt, ctrl;
    logic [3:0] calByp;
    logic [7:0] preCnt, syncL, syncM, syncH, modeCfg, txBase, preX, rdata;
  } rtps_regs_t;
endpackage

// *** rtl/rtps_radio_tx_sequencer.sv ***
// Purpose: Slot-timed transmit start and frame serialising for the radio.
// Assumes: Packet RAM answers ramAddr with ramData one cycle later.
// Notes: Bits leave MSB first, one per bit period, with a strobe each.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module rtps_radio_tx_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic csnPin,
  input wire logic rxFrameDone,
  output logic [7:0] ramAddr,
  input wire logic [7:0] ramData,
  output logic txBit,
  output logic txBitStrobe,
  output logic txActive,
  output logic paEnable,
  output logic paRampUp,
  output logic paRampDown,
  output logic extPaEnable,
  output logic synthCal,
  output logic readyIrq,
  output logic sfdIrq,
  output logic sentIrq,
  output logic rxPktIrq
);
  rtps_pkg::rtps_regs_t r;
  rtps_pkg::rtps_regs_t n;
  logic [1:0] rstSync;
  logic rstn;
  logic usTick;
  logic [10:0] total;
  logic [7:0] extEff;
  logic fsk;

  // Reset is released synchronously so no flop sees a partial release.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  assign usTick = r.usDiv == 7'(rtps_pkg::US_CYC - 1);
  assign extEff = r.extFrz ? r.extLat : r.slotExt;
  assign total = {3'h0, r.slotDly} + {1'b0, extEff, 2'h0};
  assign fsk = r.modeCfg[3:0] == rtps_pkg::MODE_FSK;

  always_comb begin
    logic tick;
    logic ld;
    logic go;
    logic fin;
    logic pend;
    logic [7:0] b;
    logic [8:0] cnt;
    logic fb;
    tick = 1'b0;
    ld = 1'b0;
    go = 1'b0;
    fin = 1'b0;
    pend = 1'b0;
    b = 8'h00;
    cnt = 9'h000;
    fb = 1'b0;
    n = r;
    n.txStb = 1'b0;
    n.rdyIrq = 1'b0;
    n.sfdIrq = 1'b0;
    n.sentIrq = 1'b0;
    n.rxIrq = 1'b0;
    n.usDiv = usTick ? 7'h00 : r.usDiv + 7'h01;
    n.csSync = {r.csSync[1:0], csnPin};
    if (r.csSync[1] == r.csSync[2]) begin
      n.csLvl = r.csSync[2];
    end
    n.csOld = r.csLvl;
    if (regWr) begin
      case (regAddr)
        rtps_pkg::PRE_CNT_OFS: n.preCnt = regWdata;
        rtps_pkg::SYNC_LO_OFS: n.syncL = regWdata;
        rtps_pkg::SYNC_MID_OFS: n.syncM = regWdata;
        rtps_pkg::SYNC_HI_OFS: n.syncH = regWdata;
        rtps_pkg::MODE_OFS: n.modeCfg = regWdata;
        rtps_pkg::TX_BASE_OFS: n.txBase = regWdata;
        rtps_pkg::PRE_EXTRA_OFS: n.preX = regWdata;
        rtps_pkg::SLOT_OFS: n.slotDly = regWdata;
        rtps_pkg::SLOT_EXT_OFS: n.slotExt = regWdata;
        rtps_pkg::CTRL_OFS: n.ctrl = regWdata;
        rtps_pkg::CAL_OFS: n.calByp = regWdata[3:0];
        default: n.rdata = r.rdata;
      endcase
    end
    n.rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        rtps_pkg::PRE_CNT_OFS: n.rdata = r.preCnt;
        rtps_pkg::SYNC_LO_OFS: n.rdata = r.syncL;
        rtps_pkg::SYNC_MID_OFS: n.rdata = r.syncM;
        rtps_pkg::SYNC_HI_OFS: n.rdata = r.syncH;
        rtps_pkg::MODE_OFS: n.rdata = r.modeCfg;
        rtps_pkg::TX_BASE_OFS: n.rdata = r.txBase;
        rtps_pkg::PRE_EXTRA_OFS: n.rdata = r.preX;
        rtps_pkg::SLOT_OFS: n.rdata = r.slotDly;
        rtps_pkg::SLOT_EXT_OFS: n.rdata = r.slotExt;
        rtps_pkg::CTRL_OFS: n.rdata = r.ctrl;
        rtps_pkg::CAL_OFS: n.rdata = {4'h0, r.calByp};
        rtps_pkg::STATUS_OFS: n.rdata = {3'h0, r.txAct, r.st};
        default: n.rdata = 8'h00;
      endcase
    end
    if (r.rxOn) begin
      n.rxCnt = r.rxCnt + 12'h001;
      if (r.rxCnt == 12'(rtps_pkg::RX_IRQ_CYC - 2)) begin
        n.rxOn = 1'b0;
        n.rxIrq = r.ctrl[rtps_pkg::RXP_IE_BIT];
      end
    end
    case (r.st)
      rtps_pkg::S_RX: begin
        if (rxFrameDone) begin
          n.rxOn = 1'b1;
          n.rxCnt = 12'h000;
          // The delay starts on the last symbol, not on the interrupt.
          go = r.ctrl[rtps_pkg::TURN_EN_BIT] &&
               r.modeCfg[3:0] == rtps_pkg::MODE_154;
        end
      end
      rtps_pkg::S_WAIT: begin
        go = r.csLvl && !r.csOld;
      end
      rtps_pkg::S_DELAY: begin
        pend = 1'b1;
        if (usTick) begin
          n.elapsed = r.elapsed + 12'h001;
        end
        if (r.elapsed >= 12'(rtps_pkg::EXT_DL_US) && !r.extFrz) begin
          n.extFrz = 1'b1;
          n.extLat = r.slotExt;
        end
        n.cal = r.calByp != rtps_pkg::CAL_SKIP &&
                r.elapsed >= 12'(rtps_pkg::PA_LEAD_US) &&
                r.elapsed < 12'(rtps_pkg::PA_LEAD_US + rtps_pkg::CAL_US);
        n.rampUp = r.elapsed + 12'(rtps_pkg::RAMP_US) >= {1'b0, total};
        if (r.elapsed >= {1'b0, total} && r.rampUp) begin
          n.st = rtps_pkg::S_PRE;
          n.paOn = 1'b1;
          n.rampUp = 1'b0;
          n.cal = 1'b0;
          n.txAct = 1'b1;
          n.rdyIrq = r.ctrl[rtps_pkg::RDY_IE_BIT];
          n.txStb = 1'b1;
          n.bitTmr = 9'h000;
          cnt = fsk ? {1'b0, r.preCnt} + {1'b0, r.preX}
                    : rtps_pkg::PRE154_N;
          n.byteCnt = cnt == 9'h000 ? 9'h000 : cnt - 9'h001;
          b = fsk ? rtps_pkg::FILL_BYTE : rtps_pkg::PRE_154;
          ld = 1'b1;
        end
      end
      rtps_pkg::S_PRE, rtps_pkg::S_SYNC, rtps_pkg::S_PAY,
      rtps_pkg::S_CRC, rtps_pkg::S_POST: begin
        tick = r.bitTmr == 9'(rtps_pkg::BIT_CYC - 1);
        n.bitTmr = tick ? 9'h000 : r.bitTmr + 9'h001;
      end
      default: n.st = r.st;
    endcase
    if (tick) begin
      n.txStb = 1'b1;
      if (r.bitCnt != 3'h7) begin
        n.sh = {r.sh[6:0], 1'b0};
        n.txBit = r.sh[6];
        n.bitCnt = r.bitCnt + 3'h1;
      end else begin
        case (r.st)
          rtps_pkg::S_PRE: begin
            ld = 1'b1;
            if (r.byteCnt != 9'h000) begin
              n.byteCnt = r.byteCnt - 9'h001;
              b = fsk ? rtps_pkg::FILL_BYTE : rtps_pkg::PRE_154;
            end else begin
              n.st = rtps_pkg::S_SYNC;
              n.byteCnt = fsk ? 9'h002 : 9'h000;
              b = fsk ? r.syncH : rtps_pkg::SFD_154;
            end
          end
          rtps_pkg::S_SYNC: begin
            if (r.byteCnt != 9'h000) begin
              ld = 1'b1;
              n.byteCnt = r.byteCnt - 9'h001;
              b = r.byteCnt == 9'h002 ? r.syncM : r.syncL;
            end else begin
              n.sfdIrq = !fsk && r.ctrl[rtps_pkg::SFD_IE_BIT];
              // The first buffer byte carries the length in both modes.
              if (fsk) begin
                cnt = {1'b0, ramData};
              end else if (!r.ctrl[rtps_pkg::CRC_OFF_BIT]) begin
                cnt = ramData[6:0] == 7'h00 ? 9'h000
                      : {2'h0, ramData[6:0]};
              end else begin
                cnt = {2'h0, ramData[6:0]} + 9'h001;
              end
              if (cnt != 9'h000) begin
                n.st = rtps_pkg::S_PAY;
                ld = 1'b1;
                b = ramData;
                n.ramAddr = r.ramAddr + 8'h01;
                n.byteCnt = cnt - 9'h001;
              end else begin
                pend = 1'b1;
              end
            end
          end
          rtps_pkg::S_PAY: begin
            if (r.byteCnt != 9'h000) begin
              ld = 1'b1;
              b = ramData;
              n.ramAddr = r.ramAddr + 8'h01;
              n.byteCnt = r.byteCnt - 9'h001;
            end else begin
              pend = 1'b1;
            end
          end
          rtps_pkg::S_CRC: begin
            if (r.byteCnt != 9'h000) begin
              ld = 1'b1;
              b = r.crc[7:0];
              n.byteCnt = 9'h000;
            end else if (fsk) begin
              ld = 1'b1;
              n.st = rtps_pkg::S_POST;
              b = rtps_pkg::FILL_BYTE;
              n.byteCnt = 9'h001;
            end else begin
              fin = 1'b1;
            end
          end
          rtps_pkg::S_POST: begin
            if (r.byteCnt != 9'h000) begin
              ld = 1'b1;
              b = rtps_pkg::FILL_BYTE;
              n.byteCnt = 9'h000;
              n.rampDn = 1'b1;
            end else begin
              fin = 1'b1;
            end
          end
          default: fin = 1'b1;
        endcase
        // Payload is done here; pend only matters in the sync/payload arms.
        if (pend && r.st != rtps_pkg::S_DELAY) begin
          if (!r.ctrl[rtps_pkg::CRC_OFF_BIT]) begin
            ld = 1'b1;
            n.st = rtps_pkg::S_CRC;
            b = r.crc[15:8];
            n.byteCnt = 9'h001;
          end else if (fsk) begin
            ld = 1'b1;
            n.st = rtps_pkg::S_POST;
            b = rtps_pkg::FILL_BYTE;
            n.byteCnt = 9'h001;
          end else begin
            fin = 1'b1;
          end
        end
      end
    end
    if (ld) begin
      n.sh = b;
      n.txBit = b[7];
      n.bitCnt = 3'h0;
    end
    if (tick && n.st == rtps_pkg::S_PAY) begin
      fb = r.crc[15] ^ n.txBit;
      n.crc = {r.crc[14:0], 1'b0} ^ (fb ? rtps_pkg::CRC_POLY : 16'h0000);
    end
    if (fin) begin
      n.st = rtps_pkg::S_RDY;
      // The closing bit period ends without a new bit, so no strobe.
      n.txStb = 1'b0;
      n.paOn = 1'b0;
      n.rampDn = 1'b0;
      n.extPa = 1'b0;
      n.txAct = 1'b0;
      n.sentIrq = r.ctrl[rtps_pkg::SENT_IE_BIT];
    end
    if (go) begin
      n.st = rtps_pkg::S_DELAY;
      n.elapsed = 12'h000;
      n.usDiv = 7'h00;
      n.extFrz = 1'b0;
      n.extPa = r.ctrl[rtps_pkg::EXTPA_EN_BIT];
      n.crc = 16'h0000;
      n.ramAddr = r.txBase;
    end
    if (cmdValid) begin
      if (cmdCode == rtps_pkg::CMD_TX) begin
        n.st = rtps_pkg::S_WAIT;
        n.rampUp = 1'b0;
        n.cal = 1'b0;
      end else if ((cmdCode == rtps_pkg::CMD_RX ||
                    cmdCode == rtps_pkg::CMD_IDLE ||
                    cmdCode == rtps_pkg::CMD_RDY) &&
                   !(r.st == rtps_pkg::S_DELAY &&
                     r.elapsed >= 12'(rtps_pkg::ABORT_US))) begin
        n.st = cmdCode == rtps_pkg::CMD_RX ? rtps_pkg::S_RX
             : cmdCode == rtps_pkg::CMD_IDLE ? rtps_pkg::S_IDLE
             : rtps_pkg::S_RDY;
        n.paOn = 1'b0;
        n.rampUp = 1'b0;
        n.rampDn = 1'b0;
        n.extPa = 1'b0;
        n.cal = 1'b0;
        n.txAct = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      // Chip-select idles high; starting the filter there avoids a false edge.
      r.csSync <= 3'h7;
      r.csLvl <= 1'b1;
      r.csOld <= 1'b1;
      r.slotDly <= rtps_pkg::SLOT_DLY_RST;
      r.slotExt <= rtps_pkg::SLOT_EXT_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  assign regRdata = r.rdata;
  assign ramAddr = r.ramAddr;
  assign txBit = r.txBit;
  assign txBitStrobe = r.txStb;
  assign txActive = r.txAct;
  assign paEnable = r.paOn;
  assign paRampUp = r.rampUp;
  assign paRampDown = r.rampDn;
  assign extPaEnable = r.extPa;
  assign synthCal = r.cal;
  assign readyIrq = r.rdyIrq;
  assign sfdIrq = r.sfdIrq;
  assign sentIrq = r.sentIrq;
  assign rxPktIrq = r.rxIrq;

  // Helper age counter for the receive interrupt check only.
  logic [11:0] hlpRx;
  logic delayDone;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hlpRx <= 12'h000;
    end else if (ce) begin
      hlpRx <= (r.st == rtps_pkg::S_RX && rxFrameDone) ? 12'h000
               : hlpRx + 12'h001;
    end
  end
  assign delayDone = ce && r.st == rtps_pkg::S_DELAY &&
                     n.st == rtps_pkg::S_PRE;

  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_reset_defaults: assert property ($rose(rstn) |->
    r.slotDly == 8'hC0 && r.slotExt == 8'h00 && !r.ctrl[0])
    else $error("Slot or CRC defaults wrong after reset.");
  a_delay_total: assert property (delayDone |->
    r.elapsed >= {1'b0, total} && r.elapsed <= {1'b0, total} + 12'h001)
    else $error("Transmit began away from the total slot delay.");
  a_ramp_first: assert property (delayDone |-> r.rampUp)
    else $error("Transmit entered before PA ramp-up.");
  a_ready_irq: assert property (
    delayDone && r.ctrl[3] |=> r.rdyIrq && r.st == rtps_pkg::S_PRE)
    else $error("Ready interrupt missing on transmit entry.");
  a_extpa_first: assert property (r.cal && r.ctrl[2] |-> r.extPa)
    else $error("Calibration ran with external PA still off.");
  a_cal_skip: assert property (
    r.st == rtps_pkg::S_DELAY && r.calByp == 4'hF |=> !r.cal)
    else $error("Calibration ran although bypassed.");
  a_cal_runs: assert property (ce && r.st == rtps_pkg::S_DELAY &&
    r.calByp == 4'h9 && r.elapsed == 12'd10 && !delayDone |=> r.cal)
    else $error("Calibration did not start.");
  a_sent_pa_off: assert property (
    r.sentIrq |-> !r.paOn && r.st == rtps_pkg::S_RDY)
    else $error("Sent interrupt with PA on or wrong state.");
  a_abort_idle: assert property (ce && cmdValid &&
    cmdCode == rtps_pkg::CMD_IDLE && r.st == rtps_pkg::S_DELAY &&
    r.elapsed < 12'd100 |=> r.st == rtps_pkg::S_IDLE && !r.extPa)
    else $error("Early idle command did not cancel transmit.");
  a_rx_irq_delay: assert property (
    r.rxIrq |-> hlpRx == 12'd3799)
    else $error("Receive interrupt not 38 us after last symbol.");
  a_sfd_mode: assert property (
    r.sfdIrq |-> r.modeCfg[3:0] == 4'h0 && r.ctrl[4] &&
    r.st != rtps_pkg::S_SYNC && r.st != rtps_pkg::S_PRE)
    else $error("SFD interrupt outside standard mode.");
  c_frame_sent: cover property (r.sentIrq);
  c_turnaround: cover property (
    ce && r.st == rtps_pkg::S_RX && n.st == rtps_pkg::S_DELAY);
  c_abort: cover property (
    r.st == rtps_pkg::S_DELAY ##1 r.st == rtps_pkg::S_IDLE);
  c_postamble: cover property ($rose(r.rampDn));
endmodule

// *** test/rtps_ram_model.sv ***
// Purpose: Packet RAM as the host fills it, read by the sequencer.
// Assumes: The bench loads mem directly before each transmit.
// Notes: Read data follow the address by one clock, like the real RAM.
`timescale 1ns/1ns
module rtps_ram_model (
  input wire logic clk,
  input wire logic [7:0] ramAddr,
  output logic [7:0] ramData
);
  // Host stores only the length and payload bytes here.
  logic [7:0] mem [0:255];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge clk) begin
    ramData <= mem[ramAddr];
  end
endmodule

// *** test/testbench.sv ***
// Purpose: Self-checking bench of the transmit packet sequencer.
// Assumes: 100 MHz clock, commands and registers driven on rising edges.
// Notes: Sent bits are gathered on each strobe and compared as bytes.
`timescale 1ns/1ns
module testbench;
  logic clk, resetn, ce, regWr, regRd, cmdValid, csnPin, rxFrameDone;
  logic [9:0] regAddr;
  logic [7:0] regWdata, regRdata, cmdCode, ramAddr, ramData;
  logic txBit, txBitStrobe, txActive, paEnable, paRampUp, paRampDown;
  logic extPaEnable, synthCal, readyIrq, sfdIrq, sentIrq, rxPktIrq;
  int err_count, total_checks, cyc, tCs, tFirst, tExt, tCal, tRamp;
  int tRdy, tRx, nSent, sfdAt, dnAt, tAct;
  logic bits[$];

  rtps_radio_tx_sequencer i_rtps_radio_tx_sequencer (.clk(clk),
    .resetn(resetn), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .csnPin(csnPin),
    .rxFrameDone(rxFrameDone), .ramAddr(ramAddr), .ramData(ramData),
    .txBit(txBit), .txBitStrobe(txBitStrobe), .txActive(txActive),
    .paEnable(paEnable), .paRampUp(paRampUp), .paRampDown(paRampDown),
    .extPaEnable(extPaEnable), .synthCal(synthCal), .readyIrq(readyIrq),
    .sfdIrq(sfdIrq), .sentIrq(sentIrq), .rxPktIrq(rxPktIrq));
  rtps_ram_model i_rtps_ram_model (.clk(clk), .ramAddr(ramAddr),
    .ramData(ramData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Event positions are kept as cycle stamps, dnAt and sfdAt as bit counts; zero means never seen.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (paRampDown === 1'b1 && dnAt == 0) dnAt <= bits.size();
    if (sfdIrq === 1'b1) sfdAt <= bits.size();
    if (txBitStrobe === 1'b1) begin
      if (bits.size() == 0) tFirst <= cyc;
      bits.push_back(txBit);
    end
    if (extPaEnable === 1'b1 && tExt == 0) tExt <= cyc;
    if (synthCal === 1'b1 && tCal == 0) tCal <= cyc;
    if (paRampUp === 1'b1 && tRamp == 0) tRamp <= cyc;
    if (readyIrq === 1'b1) tRdy <= cyc;
    if (txActive === 1'b1 && tAct == 0) tAct <= cyc;
    if (sentIrq === 1'b1) nSent <= nSent + 1;
    if (rxPktIrq === 1'b1) tRx <= cyc;
  end

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(string nm, int lo, int hi, int v);
    total_checks++;
    if (v < lo || v > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(string nm, logic [9:0] a, logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(nm, exp, regRdata);
  endtask

  // Chip-select rises after the command, which is what starts the delay.
  task automatic cmd(logic [7:0] c);
    @(posedge clk);
    csnPin <= 1'b0;
    cmdValid <= 1'b1;
    cmdCode <= c;
    @(posedge clk);
    cmdValid <= 1'b0;
    @(posedge clk);
    csnPin <= 1'b1;
    #1;
    tCs = cyc;
  endtask

  task automatic clr();
    bits.delete();
    tFirst = 0;
    tExt = 0;
    tCal = 0;
    tRamp = 0;
    tRdy = 0;
    tRx = 0;
    nSent = 0;
    sfdAt = 0;
    dnAt = 0;
    tAct = 0;
  endtask

  task automatic waitSent();
    int n;
    n = 0;
    while (nSent == 0 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    if (nSent == 0) begin
      err_count++;
      $display("CHECK FAILED sentIrq expected pulse seen none");
      end_sim();
    end
  endtask

  task automatic cmpFrame(logic [7:0] exp[$]);
    logic [7:0] b;
    chk("bitCount", exp.size() * 8, bits.size());
    foreach (exp[k]) begin
      for (int i = 0; i < 8; i++) b = {b[6:0], bits[k * 8 + i]};
      chk("frameByte", exp[k], b);
    end
  endtask

  function automatic logic [15:0] crc16(logic [15:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  task automatic t_reset();
    rd("slotDelay", rtps_pkg::SLOT_OFS, 8'hC0);
    rd("slotExt", rtps_pkg::SLOT_EXT_OFS, 8'h00);
    wr(10'h3FF, 8'h55);
    rd("unmapped", 10'h3FF, 8'h00);
    $display("Test reset done");
  endtask

  task automatic t_fsk();
    logic [7:0] e[$];
    logic [15:0] c;
    wr(rtps_pkg::MODE_OFS, 8'h04);
    wr(rtps_pkg::PRE_CNT_OFS, 8'h01);
    wr(rtps_pkg::PRE_EXTRA_OFS, 8'h01);
    wr(rtps_pkg::SYNC_HI_OFS, 8'h12);
    wr(rtps_pkg::SYNC_MID_OFS, 8'h34);
    wr(rtps_pkg::SYNC_LO_OFS, 8'h56);
    wr(rtps_pkg::TX_BASE_OFS, 8'h20);
    wr(rtps_pkg::SLOT_OFS, 8'h50);
    wr(rtps_pkg::SLOT_EXT_OFS, 8'h00);
    wr(rtps_pkg::CTRL_OFS, 8'h2C);
    wr(rtps_pkg::CAL_OFS, 8'h09);
    rd("txBase", rtps_pkg::TX_BASE_OFS, 8'h20);
    i_rtps_ram_model.mem[8'h20] = 8'h02;
    i_rtps_ram_model.mem[8'h21] = 8'hC3;
    c = crc16(16'h02C3);
    e = '{8'hAA, 8'hAA, 8'h12, 8'h34, 8'h56, 8'h02, 8'hC3};
    e.push_back(c[15:8]);
    e.push_back(c[7:0]);
    e.push_back(8'hAA);
    e.push_back(8'hAA);
    clr();
    cmd(rtps_pkg::CMD_TX);
    repeat (2000) @(posedge clk);
    wr(rtps_pkg::SLOT_EXT_OFS, 8'h05);
    waitSent();
    rng("startDelay", 10000, 10012, tFirst - tCs);
    rng("extPaLead", 1, 5000, tCal - tExt);
    rng("rampBeforeTx", 1, 1000, tFirst - tRamp);
    rng("readyAtTx", -2, 2, tFirst - tRdy);
    rng("activeAtTx", 0, 0, tFirst - tAct);
    cmpFrame(e);
    rng("rampDownBit", 80, 81, dnAt);
    $display("Test fsk done");
  endtask

  // Turnaround sends the buffered frame, or is cancelled by idle.
  task automatic t_turn(logic abort);
    logic [7:0] e[$];
    int t0;
    wr(rtps_pkg::MODE_OFS, 8'h00);
    wr(rtps_pkg::SLOT_OFS, 8'h28);
    wr(rtps_pkg::SLOT_EXT_OFS, 8'h00);
    wr(rtps_pkg::CTRL_OFS, 8'h7B);
    wr(rtps_pkg::CAL_OFS, 8'h0F);
    wr(rtps_pkg::TX_BASE_OFS, 8'h40);
    i_rtps_ram_model.mem[8'h40] = 8'h01;
    i_rtps_ram_model.mem[8'h41] = 8'h5A;
    e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'h01, 8'h5A};
    clr();
    cmd(rtps_pkg::CMD_RX);
    @(posedge clk);
    rxFrameDone <= 1'b1;
    @(posedge clk);
    rxFrameDone <= 1'b0;
    #1;
    // The idle command restamps tCs, so the frame end keeps its own stamp.
    t0 = cyc;
    if (abort) begin
      repeat (3850) @(posedge clk);
      cmd(rtps_pkg::CMD_IDLE);
      repeat (6000) @(posedge clk);
      rng("abortBits", 0, 0, bits.size());
    end else begin
      waitSent();
      rng("turnDelay", 3998, 4012, tFirst - t0);
      cmpFrame(e);
      rng("sfdPos", 39, 41, sfdAt);
      rng("calSkipped", 0, 0, tCal);
      rd("state", rtps_pkg::STATUS_OFS, 8'h01);
      chk("paOff", 1'b0, paEnable);
      chk("txActive", 1'b0, txActive);
    end
    rng("rxIrqDelay", 3795, 3805, tRx - t0);
    $display("Test turnaround abort=%0d done", abort);
  endtask

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    regAddr = 10'h000;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    csnPin = 1'b1;
    rxFrameDone = 1'b0;
    err_count = 0;
    total_checks = 0;
    cyc = 1;
    clr();
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_fsk();
    t_turn(1'b0);
    t_turn(1'b1);
    end_sim();
  end
endmodule
